// ==== verilog/tpwm_top.sv ====
// timer 1 ten-bit six-output pwm with duty, high-bits and force-drive registers
//
// Operation
// - channel b duty low byte is its own 8-bit register, reset 7f.
// - channel c duty low byte is its own read-write register, apart from b.
// - high-bits register holds duty a, b, c bits 9:8 in 7:6, 5:4, 3:2; reset 0.
// - high-bits 1:0 are period bits 9:8 above the period low byte.
// - force register: force-a, force-six, then six output enables; reset 0.
// - force-a bit one drives channel a's waveform on every pair.
// - the six output enables act only while force-six is one.
// - in force-six mode a and a-bar enables pass or block their outputs.
// - in force-six mode b and b-bar enables pass or block their outputs.
// - written period and duty go active at period match, unless immediate update.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "tpwm_defs.svh"
module tpwm_top
   import tpwm_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RESET_I,
   input wire logic [11:0] AXI_AWADDR_I,
   input wire logic AXI_AWVALID_I,
   output logic AXI_AWREADY_O,
   input wire logic [31:0] AXI_WDATA_I,
   input wire logic [3:0] AXI_WSTRB_I,
   input wire logic AXI_WVALID_I,
   output logic AXI_WREADY_O,
   output logic [1:0] AXI_BRESP_O,
   output logic AXI_BVALID_O,
   input wire logic AXI_BREADY_I,
   input wire logic [11:0] AXI_ARADDR_I,
   input wire logic AXI_ARVALID_I,
   output logic AXI_ARREADY_O,
   output logic [31:0] AXI_RDATA_O,
   output logic [1:0] AXI_RRESP_O,
   output logic AXI_RVALID_O,
   input wire logic AXI_RREADY_I,
   input wire logic TIMER0_TICK_I,
   output logic PWM_A_PIN_O,
   output logic PWM_A_BAR_PIN_O,
   output logic PWM_B_PIN_O,
   output logic PWM_B_BAR_PIN_O,
   output logic PWM_C_PIN_O,
   output logic PWM_C_BAR_PIN_O
);

   // ==========================================================================
   // bus slave
   tpwm_wr_t wr;
   logic [9:0] wr_idx, rd_idx;
   logic [7:0] rd_data;
   logic wr_ok, rd_ok;

   tpwm_axil u_axil (
      .clk_i(CLK_I),
      .reset_i(RESET_I),
      .awaddr_i(AXI_AWADDR_I),
      .awvalid_i(AXI_AWVALID_I),
      .awready_o(AXI_AWREADY_O),
      .wdata_i(AXI_WDATA_I),
      .wstrb_i(AXI_WSTRB_I),
      .wvalid_i(AXI_WVALID_I),
      .wready_o(AXI_WREADY_O),
      .bresp_o(AXI_BRESP_O),
      .bvalid_o(AXI_BVALID_O),
      .bready_i(AXI_BREADY_I),
      .araddr_i(AXI_ARADDR_I),
      .arvalid_i(AXI_ARVALID_I),
      .arready_o(AXI_ARREADY_O),
      .rdata_o(AXI_RDATA_O),
      .rresp_o(AXI_RRESP_O),
      .rvalid_o(AXI_RVALID_O),
      .rready_i(AXI_RREADY_I),
      .wr_idx_o(wr_idx),
      .wr_ok_i(wr_ok),
      .wr_o(wr),
      .rd_idx_o(rd_idx),
      .rd_ok_i(rd_ok),
      .rd_data_i(rd_data)
   );

   // ==========================================================================
   // software registers
   logic [7:0] mode_ff, period_low_ff, duty_a_low_ff, duty_b_low_ff, duty_c_low_ff;
   logic [7:0] high_bits_ff, force_output_ctrl_ff, ctrl_ff;

   function automatic logic is_mapped(input logic [9:0] idx);
      is_mapped = (idx == `TPWM_IDX_MODE) || (idx == `TPWM_IDX_DUTY_B) ||
                  (idx == `TPWM_IDX_DUTY_C) || (idx == `TPWM_IDX_HIGH) ||
                  (idx == `TPWM_IDX_FORCE) || (idx == `TPWM_IDX_PERIOD) ||
                  (idx == `TPWM_IDX_DUTY_A) || (idx == `TPWM_IDX_CTRL) ||
                  (idx == `TPWM_IDX_CNT_LO) || (idx == `TPWM_IDX_CNT_HI);
   endfunction

   // count registers are read-only; writing them is answered with an error
   wire wr_is_cnt = (wr_idx == `TPWM_IDX_CNT_LO) || (wr_idx == `TPWM_IDX_CNT_HI);
   assign wr_ok = is_mapped(wr_idx) & ~wr_is_cnt;
   assign rd_ok = is_mapped(rd_idx);

   wire hit_mode = wr.en && (wr.idx == `TPWM_IDX_MODE);
   wire hit_duty_b = wr.en && (wr.idx == `TPWM_IDX_DUTY_B);
   wire hit_duty_c = wr.en && (wr.idx == `TPWM_IDX_DUTY_C);
   wire hit_high = wr.en && (wr.idx == `TPWM_IDX_HIGH);
   wire hit_force = wr.en && (wr.idx == `TPWM_IDX_FORCE);
   wire hit_period = wr.en && (wr.idx == `TPWM_IDX_PERIOD);
   wire hit_duty_a = wr.en && (wr.idx == `TPWM_IDX_DUTY_A);
   wire hit_ctrl = wr.en && (wr.idx == `TPWM_IDX_CTRL);
   wire hit_value = hit_duty_a | hit_duty_b | hit_duty_c | hit_high | hit_period;

   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         mode_ff <= `TPWM_RST_MODE;
         period_low_ff <= `TPWM_RST_PERIOD;
         duty_a_low_ff <= `TPWM_RST_DUTY_A;
         duty_b_low_ff <= `TPWM_RST_DUTY_B;
         duty_c_low_ff <= `TPWM_RST_DUTY_C;
         high_bits_ff <= `TPWM_RST_HIGH;
         force_output_ctrl_ff <= `TPWM_RST_FORCE;
         ctrl_ff <= `TPWM_RST_CTRL;
      end else begin
         if (hit_mode) mode_ff <= wr.data;
         if (hit_period) period_low_ff <= wr.data;
         if (hit_duty_a) duty_a_low_ff <= wr.data;
         if (hit_duty_b) duty_b_low_ff <= wr.data;
         if (hit_duty_c) duty_c_low_ff <= wr.data;
         if (hit_high) high_bits_ff <= wr.data;
         if (hit_force) force_output_ctrl_ff <= wr.data;
         if (hit_ctrl) ctrl_ff <= {6'h0, wr.data[1:0]};
      end
   end

   // ==========================================================================
   // control decode
   wire pwm_enable_bit = ctrl_ff[`TPWM_CTRL_EN];
   wire immediate_update = ctrl_ff[`TPWM_CTRL_UPDT];
   wire timer_start = mode_ff[`TPWM_MODE_START];
   wire timer_continue = mode_ff[`TPWM_MODE_CONT];
   wire [3:0] clock_select = mode_ff[`TPWM_MODE_CK_LSB +: 4];
   wire force_a_bit = force_output_ctrl_ff[`TPWM_FORCE_A];
   wire force_six_bit = force_output_ctrl_ff[`TPWM_FORCE_SIX];
   wire run = pwm_enable_bit & timer_start;

   // ==========================================================================
   // holding values: high bits above each low byte
   wire [9:0] hold_period = {high_bits_ff[`TPWM_HIGH_PER_LSB +: 2], period_low_ff};
   wire [2:0][9:0] hold_duty;
   assign hold_duty[0] = {high_bits_ff[`TPWM_HIGH_A_LSB +: 2], duty_a_low_ff};
   assign hold_duty[1] = {high_bits_ff[`TPWM_HIGH_B_LSB +: 2], duty_b_low_ff};
   assign hold_duty[2] = {high_bits_ff[`TPWM_HIGH_C_LSB +: 2], duty_c_low_ff};

   // ==========================================================================
   // timer clock
   logic tick;

   tpwm_presc u_presc (
      .clk_i(CLK_I),
      .reset_i(RESET_I),
      .run_i(run),
      .sel_i(clock_select),
      .ext_tick_i(TIMER0_TICK_I),
      .tick_o(tick)
   );

   // ==========================================================================
   // counter, period match and update of the active values
   logic [9:0] cnt_ff, act_period_ff;
   logic [2:0][9:0] act_duty_ff;
   logic [1:0] sync_cnt_ff;

   wire count_tick = tick & run & timer_continue;
   wire period_match = count_tick && (cnt_ff >= act_period_ff);
   // a fresh value needs three timer ticks before an immediate load may use it
   wire sync_done = count_tick && (sync_cnt_ff == 2'h1);
   wire load_active = period_match | (sync_done & immediate_update);
   wire [1:0] nxt_sync_cnt = hit_value ? `TPWM_SYNC_TICKS :
                             (count_tick && (sync_cnt_ff != 2'h0)) ? sync_cnt_ff - 2'h1 :
                             sync_cnt_ff;
   wire [9:0] nxt_cnt = ~run ? 10'h0 :
                        period_match ? 10'h0 :
                        count_tick ? cnt_ff + 10'h1 : cnt_ff;

   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         cnt_ff <= 10'h0;
         sync_cnt_ff <= 2'h0;
         act_period_ff <= 10'({`TPWM_RST_HIGH, `TPWM_RST_PERIOD});
         act_duty_ff[0] <= 10'({`TPWM_RST_HIGH, `TPWM_RST_DUTY_A});
         act_duty_ff[1] <= 10'({`TPWM_RST_HIGH, `TPWM_RST_DUTY_B});
         act_duty_ff[2] <= 10'({`TPWM_RST_HIGH, `TPWM_RST_DUTY_C});
      end else begin
         cnt_ff <= nxt_cnt;
         sync_cnt_ff <= nxt_sync_cnt;
         if (load_active) begin
            act_period_ff <= hold_period;
            act_duty_ff <= hold_duty;
         end
      end
   end

   // ==========================================================================
   // waveforms and output gating per complementary pair
   logic [2:0] wave, pair_src;
   logic [5:0] nxt_pin, pin_ff;

   genvar ch;
   generate
      for (ch = 0; ch < 3; ch++) begin : g_pair
         localparam int POS = 5 - 2 * ch;
         localparam int NEG = 4 - 2 * ch;
         // high from counter restart until duty match
         assign wave[ch] = cnt_ff < act_duty_ff[ch];
         assign pair_src[ch] = force_a_bit ? wave[0] : wave[ch];
         // enables only matter in force-six mode
         wire pos_gate = ~force_six_bit | force_output_ctrl_ff[POS];
         wire neg_gate = ~force_six_bit | force_output_ctrl_ff[NEG];
         assign nxt_pin[POS] = pwm_enable_bit & pos_gate & pair_src[ch];
         assign nxt_pin[NEG] = pwm_enable_bit & neg_gate & ~pair_src[ch];
      end
   endgenerate

   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         pin_ff <= 6'h0;
      end else begin
         pin_ff <= nxt_pin;
      end
   end

   assign PWM_A_PIN_O = pin_ff[5];
   assign PWM_A_BAR_PIN_O = pin_ff[4];
   assign PWM_B_PIN_O = pin_ff[3];
   assign PWM_B_BAR_PIN_O = pin_ff[2];
   assign PWM_C_PIN_O = pin_ff[1];
   assign PWM_C_BAR_PIN_O = pin_ff[0];

   // ==========================================================================
   // read selection
   wire sync_busy = sync_cnt_ff != 2'h0;
   assign rd_data =
      (rd_idx == `TPWM_IDX_MODE) ? mode_ff :
      (rd_idx == `TPWM_IDX_DUTY_B) ? duty_b_low_ff :
      (rd_idx == `TPWM_IDX_DUTY_C) ? duty_c_low_ff :
      (rd_idx == `TPWM_IDX_HIGH) ? high_bits_ff :
      (rd_idx == `TPWM_IDX_FORCE) ? force_output_ctrl_ff :
      (rd_idx == `TPWM_IDX_PERIOD) ? period_low_ff :
      (rd_idx == `TPWM_IDX_DUTY_A) ? duty_a_low_ff :
      (rd_idx == `TPWM_IDX_CTRL) ? {sync_busy, ctrl_ff[6:0]} :
      (rd_idx == `TPWM_IDX_CNT_LO) ? cnt_ff[7:0] :
      (rd_idx == `TPWM_IDX_CNT_HI) ? {6'h0, cnt_ff[9:8]} : 8'h0;

   // ==========================================================================
   // checks
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RESET_I);

   property p_duty_b_reset;
      $fell(RESET_I) |-> (duty_b_low_ff == 8'h7f) && (high_bits_ff == 8'h00);
   endproperty
   a_duty_b_reset: assert property (p_duty_b_reset) else $error("duty b reset wrong");

   property p_duty_c_apart;
      hit_duty_c |=> (duty_c_low_ff == $past(wr.data)) && $stable(duty_b_low_ff);
   endproperty
   a_duty_c_apart: assert property (p_duty_c_apart) else $error("duty c write wrong");

   property p_high_split;
      hit_high |=> (hold_duty[0][9:8] == $past(wr.data[7:6])) &&
                   (hold_duty[1][9:8] == $past(wr.data[5:4])) &&
                   (hold_duty[2][9:8] == $past(wr.data[3:2]));
   endproperty
   a_high_split: assert property (p_high_split) else $error("duty high bits misplaced");

   property p_period_high;
      period_match |=> act_period_ff[9:8] == $past(high_bits_ff[1:0]);
   endproperty
   a_period_high: assert property (p_period_high) else $error("period high bits wrong");

   property p_force_reset;
      $fell(RESET_I) |-> (force_output_ctrl_ff == 8'h00) && !PWM_A_PIN_O;
   endproperty
   a_force_reset: assert property (p_force_reset) else $error("force reg reset wrong");

   property p_force_a;
      (pwm_enable_bit && force_a_bit && !force_six_bit) |=> PWM_C_PIN_O == $past(wave[0]);
   endproperty
   a_force_a: assert property (p_force_a) else $error("force a not driving c");

   property p_enables_ignored;
      (pwm_enable_bit && !force_six_bit && !force_a_bit) |=>
         (PWM_A_PIN_O == $past(wave[0])) && (PWM_B_BAR_PIN_O == !$past(wave[1]));
   endproperty
   a_enables_ignored: assert property (p_enables_ignored) else $error("enables leak");

   property p_block_a;
      (force_six_bit && !force_output_ctrl_ff[5]) |=> !PWM_A_PIN_O;
   endproperty
   a_block_a: assert property (p_block_a) else $error("a not blocked");

   property p_pass_b_bar;
      (pwm_enable_bit && force_six_bit && !force_a_bit && force_output_ctrl_ff[2]) |=>
         PWM_B_BAR_PIN_O == !$past(wave[1]);
   endproperty
   a_pass_b_bar: assert property (p_pass_b_bar) else $error("b bar not passed");

   property p_load_at_match;
      period_match && !hit_value |=> act_duty_ff[1] == $past(hold_duty[1]);
   endproperty
   a_load_at_match: assert property (p_load_at_match) else $error("no load at match");

   property p_hold_until_match;
      (!load_active && run) |=> $stable(act_period_ff);
   endproperty
   a_hold_until_match: assert property (p_hold_until_match) else $error("early load");

   property p_block_c_bar;
      (force_six_bit && !force_output_ctrl_ff[0]) |=> !PWM_C_BAR_PIN_O;
   endproperty
   a_block_c_bar: assert property (p_block_c_bar) else $error("c bar not blocked");

   property p_count_step;
      (count_tick && (cnt_ff < act_period_ff)) |=> cnt_ff == $past(cnt_ff) + 10'h1;
   endproperty
   a_count_step: assert property (p_count_step) else $error("counter step wrong");

   property p_count_restart;
      period_match |=> cnt_ff == 10'h0;
   endproperty
   a_count_restart: assert property (p_count_restart) else $error("no restart");

endmodule
`default_nettype wire

// ==== shared/tpwm_defs.svh ====
// register map, field positions, reset values and timing counts of the timer 1 pwm block
`ifndef TPWM_DEFS_SVH
`define TPWM_DEFS_SVH

// ==========================================================================
// register indexes (byte address = index * 4)
`define TPWM_IDX_MODE 10'h0b4
`define TPWM_IDX_DUTY_B 10'h0ba
`define TPWM_IDX_DUTY_C 10'h0bb
`define TPWM_IDX_HIGH 10'h0bc
`define TPWM_IDX_FORCE 10'h0bd
`define TPWM_IDX_PERIOD 10'h0c0
`define TPWM_IDX_DUTY_A 10'h0c1
`define TPWM_IDX_CTRL 10'h0c2
`define TPWM_IDX_CNT_LO 10'h0c3
`define TPWM_IDX_CNT_HI 10'h0c4

// ==========================================================================
// reset values
`define TPWM_RST_MODE 8'h00
`define TPWM_RST_DUTY_B 8'h7f
`define TPWM_RST_DUTY_C 8'h7f
`define TPWM_RST_HIGH 8'h00
`define TPWM_RST_FORCE 8'h00
`define TPWM_RST_PERIOD 8'hff
`define TPWM_RST_DUTY_A 8'h7f
`define TPWM_RST_CTRL 8'h00

// ==========================================================================
// field positions
`define TPWM_MODE_CK_LSB 0
`define TPWM_MODE_START 4
`define TPWM_MODE_CONT 5
`define TPWM_CTRL_EN 0
`define TPWM_CTRL_UPDT 1
`define TPWM_CTRL_BUSY 7
`define TPWM_FORCE_A 7
`define TPWM_FORCE_SIX 6
`define TPWM_HIGH_PER_LSB 0
`define TPWM_HIGH_C_LSB 2
`define TPWM_HIGH_B_LSB 4
`define TPWM_HIGH_A_LSB 6

// ==========================================================================
// timing and bus answers
`define TPWM_SYNC_TICKS 2'h3
`define TPWM_CK_EXT 4'hf
`define TPWM_RESP_OKAY 2'h0
`define TPWM_RESP_SLVERR 2'h2

`endif

// ==== shared/tpwm_pkg.sv ====
// types shared by the timer 1 pwm block
package tpwm_pkg;

   // ==========================================================================
   // register write strobe from the bus slave
   typedef struct packed {
      logic en;
      logic [9:0] idx;
      logic [7:0] data;
   } tpwm_wr_t;

   // ==========================================================================
   // read channel states
   typedef enum logic [2:0] {
      RS_IDLE = 3'h1,
      RS_FETCH = 3'h2,
      RS_DATA = 3'h4
   } tpwm_rstate_t;

endpackage

// ==== verilog/tpwm_presc.sv ====
// timer clock prescaler: one-cycle tick at fx / 2^sel, or the timer 0 tick
`timescale 1ns/100ps
`default_nettype none
`include "tpwm_defs.svh"
module tpwm_presc (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic run_i,
   input wire logic [3:0] sel_i,
   input wire logic ext_tick_i,
   output logic tick_o
);

   logic [13:0] div_ff;
   logic tick_ff;
   wire [14:0] full_mask = (15'h1 << sel_i) - 15'h1;
   wire [13:0] mask = full_mask[13:0];
   wire div_hit = (div_ff & mask) == mask;
   wire nxt_tick = run_i & ((sel_i == `TPWM_CK_EXT) ? ext_tick_i : div_hit);

   // ==========================================================================
   // divider restarts when stopped so the first period is full length
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         div_ff <= 14'h0;
         tick_ff <= 1'b0;
      end else begin
         div_ff <= run_i ? div_ff + 14'h1 : 14'h0;
         tick_ff <= nxt_tick;
      end
   end

   assign tick_o = tick_ff;

endmodule
`default_nettype wire

// ==== verilog/tpwm_axil.sv ====
// axi4-lite slave front end: one write and one read at a time, 8-bit registers in lane 0
`timescale 1ns/100ps
`default_nettype none
`include "tpwm_defs.svh"
module tpwm_axil
   import tpwm_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [11:0] awaddr_i,
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic wvalid_i,
   output logic wready_o,
   output logic [1:0] bresp_o,
   output logic bvalid_o,
   input wire logic bready_i,
   input wire logic [11:0] araddr_i,
   input wire logic arvalid_i,
   output logic arready_o,
   output logic [31:0] rdata_o,
   output logic [1:0] rresp_o,
   output logic rvalid_o,
   input wire logic rready_i,
   output logic [9:0] wr_idx_o,
   input wire logic wr_ok_i,
   output tpwm_wr_t wr_o,
   output logic [9:0] rd_idx_o,
   input wire logic rd_ok_i,
   input wire logic [7:0] rd_data_i
);

   logic aw_held_ff, w_held_ff, awready_ff, wready_ff, bvalid_ff, lane0_ff;
   logic arready_ff, rvalid_ff;
   logic [9:0] aw_idx_ff, ar_idx_ff;
   logic [7:0] wdata_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;
   tpwm_wr_t wr_ff;
   tpwm_rstate_t rstate_ff;

   // ==========================================================================
   // write channel: address and data taken in either order, answer after both
   wire aw_take = awvalid_i & awready_ff;
   wire w_take = wvalid_i & wready_ff;
   wire fire = aw_held_ff & w_held_ff & ~bvalid_ff;
   wire nxt_aw_held = aw_held_ff ? ~fire : aw_take;
   wire nxt_w_held = w_held_ff ? ~fire : w_take;
   wire ar_take = arvalid_i & arready_ff;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
         bvalid_ff <= 1'b0;
         bresp_ff <= `TPWM_RESP_OKAY;
         aw_idx_ff <= 10'h0;
         wdata_ff <= 8'h0;
         lane0_ff <= 1'b0;
         wr_ff <= '0;
      end else begin
         aw_held_ff <= nxt_aw_held;
         w_held_ff <= nxt_w_held;
         awready_ff <= ~nxt_aw_held;
         wready_ff <= ~nxt_w_held;
         if (aw_take) begin
            aw_idx_ff <= awaddr_i[11:2];
         end
         if (w_take) begin
            wdata_ff <= wdata_i[7:0];
            lane0_ff <= wstrb_i[0];
         end
         if (fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_ok_i ? `TPWM_RESP_OKAY : `TPWM_RESP_SLVERR;
         end else if (bready_i) begin
            bvalid_ff <= 1'b0;
         end
         // a write without lane 0 is answered but stores nothing
         wr_ff <= '{en: fire & wr_ok_i & lane0_ff, idx: aw_idx_ff, data: wdata_ff};
      end
   end

   // ==========================================================================
   // read channel
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rstate_ff <= RS_IDLE;
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         ar_idx_ff <= 10'h0;
         rdata_ff <= 32'h0;
         rresp_ff <= `TPWM_RESP_OKAY;
      end else begin
         unique case (rstate_ff)
            RS_IDLE: begin
               if (ar_take) begin
                  ar_idx_ff <= araddr_i[11:2];
                  arready_ff <= 1'b0;
                  rstate_ff <= RS_FETCH;
               end
            end
            RS_FETCH: begin
               rdata_ff <= {24'h0, rd_ok_i ? rd_data_i : 8'h0};
               rresp_ff <= rd_ok_i ? `TPWM_RESP_OKAY : `TPWM_RESP_SLVERR;
               rvalid_ff <= 1'b1;
               rstate_ff <= RS_DATA;
            end
            RS_DATA: begin
               if (rready_i) begin
                  rvalid_ff <= 1'b0;
                  arready_ff <= 1'b1;
                  rstate_ff <= RS_IDLE;
               end
            end
         endcase
      end
   end

   assign awready_o = awready_ff;
   assign wready_o = wready_ff;
   assign bvalid_o = bvalid_ff;
   assign bresp_o = bresp_ff;
   assign arready_o = arready_ff;
   assign rvalid_o = rvalid_ff;
   assign rdata_o = rdata_ff;
   assign rresp_o = rresp_ff;
   assign wr_idx_o = aw_idx_ff;
   assign wr_o = wr_ff;
   assign rd_idx_o = ar_idx_ff;

endmodule
`default_nettype wire

// ==== bench/tpwm_top_tb_top.sv ====
// self-checking bench for the timer 1 pwm block
`timescale 1ns/100ps
`default_nettype none
`include "tpwm_defs.svh"
module tpwm_top_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic awv = 1'b0;
   logic wv = 1'b0;
   logic bry = 1'b0;
   logic arv = 1'b0;
   logic rry = 1'b0;
   logic t0 = 1'b0;
   logic [3:0] ws = 4'h1;
   logic [11:0] awa = 12'h000;
   logic [11:0] ara = 12'h000;
   logic [31:0] wd = 32'h0;
   wire logic awr, wrr, bv, arr, rv;
   wire logic [1:0] br, rr;
   wire logic [31:0] rd;
   wire logic [5:0] pin;
   int err_total = 0;
   int check_count = 0;
   int cyc = 0;
   logic [33:0] qr[$];
   logic [1:0] qb[$];
   logic [15:0] lf = 16'h37ea;
   logic [9:0] ix[3] = '{`TPWM_IDX_DUTY_C, `TPWM_IDX_HIGH, `TPWM_IDX_FORCE};

   tpwm_top dut_u (.CLK_I(clk), .RESET_I(rst), .AXI_AWADDR_I(awa), .AXI_AWVALID_I(awv),
      .AXI_AWREADY_O(awr), .AXI_WDATA_I(wd), .AXI_WSTRB_I(ws), .AXI_WVALID_I(wv),
      .AXI_WREADY_O(wrr), .AXI_BRESP_O(br), .AXI_BVALID_O(bv), .AXI_BREADY_I(bry),
      .AXI_ARADDR_I(ara), .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arr), .AXI_RDATA_O(rd),
      .AXI_RRESP_O(rr), .AXI_RVALID_O(rv), .AXI_RREADY_I(rry), .TIMER0_TICK_I(t0),
      .PWM_A_PIN_O(pin[5]), .PWM_A_BAR_PIN_O(pin[4]), .PWM_B_PIN_O(pin[3]),
      .PWM_B_BAR_PIN_O(pin[2]), .PWM_C_PIN_O(pin[1]), .PWM_C_BAR_PIN_O(pin[0]));

   initial forever #2.5 clk = ~clk;

   // ====================
   // helpers
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic chk(input logic [33:0] e, input logic [33:0] g);
      check_count++;
      if (e !== g) begin
         err_total++;
         $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   task automatic summarize;
      $display("checks=%0d errors=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // each task starts one edge later, so no signal is assigned twice in a time step
   task automatic wr(input logic [9:0] i, input logic [7:0] d, input logic [1:0] r);
      @(posedge clk);
      qb.push_back(r);
      awa <= {i, 2'h0};
      wd <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrr) wv <= 1'b0;
      end while (!bv);
      bry <= 1'b0;
   endtask

   task automatic rdc(input logic [9:0] i, input logic [33:0] e);
      @(posedge clk);
      qr.push_back(e);
      ara <= {i, 2'h0};
      arv <= 1'b1;
      rry <= 1'b1;
      do @(posedge clk); while (!arr);
      arv <= 1'b0;
      do @(posedge clk); while (!rv);
      rry <= 1'b0;
   endtask

   task automatic pins(input logic [5:0] m, input logic [5:0] e);
      repeat (300) @(posedge clk);
      repeat (8) begin
         @(posedge clk);
         chk({28'h0, e}, {28'h0, pin & m});
      end
   endtask

   // ====================
   // result watcher and hang limit
   always @(posedge clk) begin
      if (rv && rry) chk(qr.pop_front(), {rr, rd});
      if (bv && bry) chk({32'h0, qb.pop_front()}, {32'h0, br});
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         summarize;
      end
   end

   // ====================
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rdc(`TPWM_IDX_DUTY_B, 34'h7f);
      rdc(`TPWM_IDX_DUTY_C, 34'h7f);
      rdc(`TPWM_IDX_HIGH, 34'h0);
      rdc(`TPWM_IDX_FORCE, 34'h0);
      wr(`TPWM_IDX_CTRL, 8'h01, 2'h0);
      for (int k = 0; k < 3; k++) begin
         lf = lfsr(lf);
         wr(ix[k], lf[7:0], 2'h0);
         rdc(ix[k], {26'h0, lf[7:0]});
      end
      rdc(10'h000, {2'h2, 32'h0});
      wr(`TPWM_IDX_CNT_LO, 8'h5a, 2'h2);
      wr(`TPWM_IDX_HIGH, 8'h00, 2'h0);
      wr(`TPWM_IDX_PERIOD, 8'h0f, 2'h0);
      wr(`TPWM_IDX_DUTY_B, 8'h00, 2'h0);
      wr(`TPWM_IDX_MODE, 8'h30, 2'h0);
      wr(`TPWM_IDX_FORCE, 8'h40, 2'h0);
      pins(6'h3f, 6'h00);
      wr(`TPWM_IDX_FORCE, 8'h64, 2'h0);
      pins(6'h3f, 6'h24);
      wr(`TPWM_IDX_FORCE, 8'h1f, 2'h0);
      pins(6'h3c, 6'h24);
      wr(`TPWM_IDX_FORCE, 8'h80, 2'h0);
      pins(6'h3f, 6'h2a);
      summarize;
   end
endmodule
`default_nettype wire
